// *** core/ctw_cfg.svh ***
// Opcodes, condition code bit positions, register offsets and reset values
`ifndef CTW_CFG_SVH
`define CTW_CFG_SVH
`define CTW_OP_PREFIX_Y     8'h18
`define CTW_OP_TEST_ACCUM_A 8'h4D
`define CTW_OP_TEST_ACCUM_B 8'h5D
`define CTW_OP_TEST_EXT     8'h7D
`define CTW_OP_TEST_IDX     8'h6D
`define CTW_OP_STACK_TO_IDX 8'h30
`define CTW_OP_IDX_TO_STACK 8'h35
`define CTW_OP_WAIT         8'h3E
`define CTW_OP_SWAP_DBL     8'h8F
`define CTW_IDLE_ADDR       16'hFFFF
`define CTW_CC_X            6
`define CTW_CC_I            4
`define CTW_CC_N            3
`define CTW_CC_Z            2
`define CTW_CC_RESET        8'hD0
`define CTW_PUSH_LAST       4'h8
`define CTW_REG_DBL         3'h0
`define CTW_REG_IDX_X       3'h1
`define CTW_REG_IDX_Y       3'h2
`define CTW_REG_SP          3'h3
`define CTW_REG_PC          3'h4
`define CTW_REG_CC          3'h5
`define CTW_REG_STATUS      3'h6
`define CTW_REG_RUN         3'h7
`endif

// *** core/ctw_pkg.sv ***
// Types shared by the core: sequencer states and one bus cycle
package ctw_pkg;
    typedef enum logic [2:0] {
        ST_FETCH, ST_PRE, ST_OP2, ST_RUN, ST_WAIT, ST_VEC_HI, ST_VEC_LO
    } ctw_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rw;
    } ctw_bus_t;
endpackage : ctw_pkg

// *** core/ctw_core.sv ***
// Core executing operand test, stack transfers, swaps and wait-for-interrupt
// How it works
// - Operand test sets N from bit 7, Z on zero, clears V and C, keeps the operand.
// - Test opcodes 4D/5D take 2 cycles, 7D/6D take 6, 18 6D takes 7, idle cycles read FFFF.
// - Opcode 30 loads X with SP plus one in 3 cycles, the third reading at SP.
// - Prefix 18 with 30 loads Y with SP plus one in 4 cycles, the last reading at SP.
// - Opcode 35 loads SP with X minus one in 3 cycles, the third reading FFFF.
// - Prefix 18 with 35 loads SP with Y minus one in 4 cycles, the last reading FFFF.
// - Wait 3E pushes return, Y, X, A, B and flags in cycles 3 to 11, SP down per byte.
// - While waiting the bus keeps reading the address of the stacked flag byte.
// - Waiting lasts until an unmasked interrupt is seen, then it ends.
// - Leaving wait sets I, reads vector high then low and resumes there.
// - A nonmaskable external wake also sets X; the wait itself changes no flag.
// - Opcode 8F swaps the double accumulator with X in 3 cycles, the third reading FFFF.
// - Prefix 18 with 8F swaps the double accumulator with Y in 4 cycles, last reading FFFF.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "ctw_cfg.svh"
module ctw_core
#(
    parameter logic [15:0] RESET_PC = 16'h0000, // First fetch address
    parameter logic [15:0] VEC_IRQ  = 16'hFFF0, // Maskable vector
    parameter logic [15:0] VEC_NMX  = 16'hFFF2  // Nonmaskable external vector
)
(
    input  wire logic              core_clk,      // Clock
    input  wire logic              reset,         // Sync reset
    input  wire logic [7:0]        busRdata,      // Read data of this cycle
    input  wire logic              irqReq,        // Maskable request
    input  wire logic              nonmaskExtReq, // Nonmaskable external req
    input  wire logic [2:0]        regAddr,       // Register index
    input  wire logic [15:0]       regWdata,      // Register write data
    input  wire logic              regWr,         // Write strobe
    input  wire logic              regRd,         // Read strobe
    output ctw_pkg::ctw_bus_t      bus,           // Address, data, rw
    output logic [15:0]            regRdata       // Read data, next cycle
);
    ctw_pkg::ctw_state_t state_ff;
    ctw_pkg::ctw_state_t nxt_state;
    ctw_pkg::ctw_bus_t   bus_ff;
    ctw_pkg::ctw_bus_t   nxt_bus;
    logic [7:0]  op_ff;
    logic [7:0]  nxt_op;
    logic        preY_ff;
    logic        nxt_preY;
    logic [3:0]  step_ff;
    logic [3:0]  nxt_step;
    logic [7:0]  tmp_ff;
    logic [7:0]  nxt_tmp;
    logic        run_ff;
    logic        nxt_run;
    logic [15:0] pc_ff;
    logic [15:0] nxt_pc;
    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic [15:0] idxX_ff;
    logic [15:0] nxt_idxX;
    logic [15:0] idxY_ff;
    logic [15:0] nxt_idxY;
    logic [15:0] dbl_ff;
    logic [15:0] nxt_dbl;
    logic [7:0]  cc_ff;
    logic [7:0]  nxt_cc;
    logic [15:0] regRdata_ff;
    logic [15:0] curIdx;
    logic [7:0]  wrSel;
    logic [3:0]  pushIdx;
    logic [7:0]  pushData;
    logic        wakeNmx;
    logic        wakeIrq;

    function automatic ctw_pkg::ctw_bus_t rdCyc(input logic [15:0] a);
        rdCyc = '{a, 8'h00, 1'b1};
    endfunction : rdCyc

    function automatic ctw_pkg::ctw_bus_t wrCyc(input logic [15:0] a,
                                                 input logic [7:0]  d);
        wrCyc = '{a, d, 1'b0};
    endfunction : wrCyc

    function automatic logic [7:0] testFlags(input logic [7:0] cc,
                                             input logic [7:0] v);
        testFlags = cc;
        testFlags[`CTW_CC_N] = v[7];
        testFlags[`CTW_CC_Z] = (v == 8'h00);
        testFlags[1:0] = 2'b00;
    endfunction : testFlags

    assign curIdx  = preY_ff ? idxY_ff : idxX_ff;
    assign wrSel   = regWr ? 8'(8'h01 << regAddr) : 8'h00;
    assign wakeNmx = nonmaskExtReq && !cc_ff[`CTW_CC_X];
    assign wakeIrq = irqReq && !cc_ff[`CTW_CC_I];
    assign bus      = bus_ff;
    assign regRdata = regRdata_ff;

    // Stack order: return lo/hi, Y lo/hi, X lo/hi, A, B, flags
    always_comb
    begin
        pushIdx = (state_ff == ctw_pkg::ST_RUN) ? step_ff + 4'h1 : 4'h0;
        case (pushIdx)
            4'h0:    pushData = pc_ff[7:0];
            4'h1:    pushData = pc_ff[15:8];
            4'h2:    pushData = idxY_ff[7:0];
            4'h3:    pushData = idxY_ff[15:8];
            4'h4:    pushData = idxX_ff[7:0];
            4'h5:    pushData = idxX_ff[15:8];
            4'h6:    pushData = dbl_ff[15:8];
            4'h7:    pushData = dbl_ff[7:0];
            default: pushData = cc_ff;
        endcase
    end

    // Software writes first; execution below overrides them in the same cycle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_op    = op_ff;
        nxt_preY  = preY_ff;
        nxt_step  = step_ff;
        nxt_tmp   = tmp_ff;
        nxt_run   = wrSel[`CTW_REG_RUN] ? regWdata[0] : run_ff;
        nxt_dbl   = wrSel[`CTW_REG_DBL] ? regWdata : dbl_ff;
        nxt_idxX  = wrSel[`CTW_REG_IDX_X] ? regWdata : idxX_ff;
        nxt_idxY  = wrSel[`CTW_REG_IDX_Y] ? regWdata : idxY_ff;
        nxt_sp    = wrSel[`CTW_REG_SP] ? regWdata : sp_ff;
        nxt_pc    = wrSel[`CTW_REG_PC] ? regWdata : pc_ff;
        nxt_cc    = wrSel[`CTW_REG_CC] ? regWdata[7:0] : cc_ff;
        nxt_bus   = rdCyc(bus_ff.addr);
        case (state_ff)
            ctw_pkg::ST_FETCH:
            begin
                nxt_step = 4'h0;
                // Halted core keeps pointing at pc so a pc write redirects it
                if (!run_ff)
                    nxt_bus = rdCyc(nxt_pc);
                else
                begin
                    nxt_op    = busRdata;
                    nxt_preY  = (busRdata == `CTW_OP_PREFIX_Y);
                    nxt_pc    = pc_ff + 16'h0001;
                    nxt_bus   = rdCyc(pc_ff + 16'h0001);
                    nxt_state = nxt_preY ? ctw_pkg::ST_PRE : ctw_pkg::ST_OP2;
                end
            end
            ctw_pkg::ST_PRE:
            begin
                nxt_op    = busRdata;
                nxt_pc    = pc_ff + 16'h0001;
                nxt_bus   = rdCyc(pc_ff + 16'h0001);
                nxt_state = ctw_pkg::ST_OP2;
            end
            ctw_pkg::ST_OP2:
            begin
                nxt_state = ctw_pkg::ST_RUN;
                case (op_ff)
                    `CTW_OP_TEST_ACCUM_A:
                    begin
                        nxt_cc    = testFlags(cc_ff, dbl_ff[15:8]);
                        nxt_bus   = rdCyc(pc_ff);
                        nxt_state = ctw_pkg::ST_FETCH;
                    end
                    `CTW_OP_TEST_ACCUM_B:
                    begin
                        nxt_cc    = testFlags(cc_ff, dbl_ff[7:0]);
                        nxt_bus   = rdCyc(pc_ff);
                        nxt_state = ctw_pkg::ST_FETCH;
                    end
                    `CTW_OP_TEST_EXT:
                    begin
                        nxt_tmp = busRdata;
                        nxt_pc  = pc_ff + 16'h0001;
                        nxt_bus = rdCyc(pc_ff + 16'h0001);
                    end
                    `CTW_OP_TEST_IDX:
                    begin
                        nxt_tmp = busRdata;
                        nxt_pc  = pc_ff + 16'h0001;
                        nxt_bus = rdCyc(`CTW_IDLE_ADDR);
                    end
                    `CTW_OP_STACK_TO_IDX:
                        nxt_bus = rdCyc(sp_ff);
                    `CTW_OP_IDX_TO_STACK:
                        nxt_bus = rdCyc(`CTW_IDLE_ADDR);
                    `CTW_OP_SWAP_DBL:
                        nxt_bus = rdCyc(`CTW_IDLE_ADDR);
                    // Return address is already pc, bumped past the opcode
                    `CTW_OP_WAIT:
                        nxt_bus = wrCyc(sp_ff, pushData);
                    // Opcodes outside this group pass as two-cycle no-ops
                    default:
                    begin
                        nxt_bus   = rdCyc(pc_ff);
                        nxt_state = ctw_pkg::ST_FETCH;
                    end
                endcase
            end
            ctw_pkg::ST_RUN:
            begin
                nxt_step  = step_ff + 4'h1;
                nxt_bus   = rdCyc(pc_ff);
                nxt_state = ctw_pkg::ST_FETCH;
                case (op_ff)
                    `CTW_OP_STACK_TO_IDX:
                    begin
                        if (preY_ff)
                            nxt_idxY = sp_ff + 16'h0001;
                        else
                            nxt_idxX = sp_ff + 16'h0001;
                    end
                    `CTW_OP_IDX_TO_STACK:
                        nxt_sp = curIdx - 16'h0001;
                    `CTW_OP_SWAP_DBL:
                    begin
                        nxt_dbl = curIdx;
                        if (preY_ff)
                            nxt_idxY = dbl_ff;
                        else
                            nxt_idxX = dbl_ff;
                    end
                    `CTW_OP_TEST_EXT, `CTW_OP_TEST_IDX:
                    begin
                        nxt_state = ctw_pkg::ST_RUN;
                        case (step_ff)
                            4'h0:
                            begin
                                if (op_ff == `CTW_OP_TEST_EXT)
                                begin
                                    nxt_pc  = pc_ff + 16'h0001;
                                    nxt_bus = rdCyc({tmp_ff, busRdata});
                                end
                                else
                                    nxt_bus = rdCyc(curIdx + {8'h00, tmp_ff});
                            end
                            4'h1:
                            begin
                                nxt_cc  = testFlags(cc_ff, busRdata);
                                nxt_bus = rdCyc(`CTW_IDLE_ADDR);
                            end
                            4'h2:
                                nxt_bus = rdCyc(`CTW_IDLE_ADDR);
                            default:
                                nxt_state = ctw_pkg::ST_FETCH;
                        endcase
                    end
                    `CTW_OP_WAIT:
                    begin
                        nxt_sp = sp_ff - 16'h0001;
                        if (step_ff == `CTW_PUSH_LAST)
                        begin
                            nxt_bus   = rdCyc(sp_ff);
                            nxt_state = ctw_pkg::ST_WAIT;
                        end
                        else
                        begin
                            nxt_bus   = wrCyc(sp_ff - 16'h0001, pushData);
                            nxt_state = ctw_pkg::ST_RUN;
                        end
                    end
                    default:
                        nxt_state = ctw_pkg::ST_FETCH;
                endcase
            end
            // External source outranks the maskable one
            ctw_pkg::ST_WAIT:
            begin
                if (wakeNmx)
                begin
                    nxt_cc[`CTW_CC_X] = 1'b1;
                    nxt_cc[`CTW_CC_I] = 1'b1;
                    nxt_bus   = rdCyc(VEC_NMX);
                    nxt_state = ctw_pkg::ST_VEC_HI;
                end
                else if (wakeIrq)
                begin
                    nxt_cc[`CTW_CC_I] = 1'b1;
                    nxt_bus   = rdCyc(VEC_IRQ);
                    nxt_state = ctw_pkg::ST_VEC_HI;
                end
            end
            ctw_pkg::ST_VEC_HI:
            begin
                nxt_tmp   = busRdata;
                nxt_bus   = rdCyc(bus_ff.addr + 16'h0001);
                nxt_state = ctw_pkg::ST_VEC_LO;
            end
            ctw_pkg::ST_VEC_LO:
            begin
                nxt_pc    = {tmp_ff, busRdata};
                nxt_bus   = rdCyc({tmp_ff, busRdata});
                nxt_state = ctw_pkg::ST_FETCH;
            end
            default:
                nxt_state = ctw_pkg::ST_FETCH;
        endcase
    end

    always_ff @(posedge core_clk)
        if (reset)
        begin
            state_ff <= ctw_pkg::ST_FETCH;
            op_ff    <= 8'h00;
            preY_ff  <= 1'b0;
            step_ff  <= 4'h0;
            tmp_ff   <= 8'h00;
            bus_ff   <= '{RESET_PC, 8'h00, 1'b1};
        end
        else
        begin
            state_ff <= nxt_state;
            op_ff    <= nxt_op;
            preY_ff  <= nxt_preY;
            step_ff  <= nxt_step;
            tmp_ff   <= nxt_tmp;
            bus_ff   <= nxt_bus;
        end

    always_ff @(posedge core_clk)
        if (reset)
        begin
            run_ff  <= 1'b0;
            pc_ff   <= RESET_PC;
            sp_ff   <= 16'h0000;
            idxX_ff <= 16'h0000;
            idxY_ff <= 16'h0000;
            dbl_ff  <= 16'h0000;
            cc_ff   <= `CTW_CC_RESET;
        end
        else
        begin
            run_ff  <= nxt_run;
            pc_ff   <= nxt_pc;
            sp_ff   <= nxt_sp;
            idxX_ff <= nxt_idxX;
            idxY_ff <= nxt_idxY;
            dbl_ff  <= nxt_dbl;
            cc_ff   <= nxt_cc;
        end

    always_ff @(posedge core_clk)
        if (reset || !regRd)
            regRdata_ff <= 16'h0000;
        else
            case (regAddr)
                `CTW_REG_DBL:    regRdata_ff <= dbl_ff;
                `CTW_REG_IDX_X:  regRdata_ff <= idxX_ff;
                `CTW_REG_IDX_Y:  regRdata_ff <= idxY_ff;
                `CTW_REG_SP:     regRdata_ff <= sp_ff;
                `CTW_REG_PC:     regRdata_ff <= pc_ff;
                `CTW_REG_CC:     regRdata_ff <= {8'h00, cc_ff};
                `CTW_REG_STATUS: regRdata_ff <= {op_ff, 3'h0, preY_ff, 1'b0, state_ff};
                default:         regRdata_ff <= {15'h0000, run_ff};
            endcase

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_pushes;
        (!bus_ff.rw && bus_ff.addr == sp_ff) [*8] ##1 (!bus_ff.rw && bus_ff.addr == sp_ff);
    endsequence
    sequence s_vector;
        (state_ff == ctw_pkg::ST_VEC_HI && cc_ff[`CTW_CC_I])
        ##1 (state_ff == ctw_pkg::ST_VEC_LO && bus_ff.addr == $past(bus_ff.addr) + 16'h0001)
        ##1 (state_ff == ctw_pkg::ST_FETCH && pc_ff == bus_ff.addr);
    endsequence

    property p_test_flags;
        (state_ff == ctw_pkg::ST_OP2 && op_ff == `CTW_OP_TEST_ACCUM_A && !regWr) |=>
        (cc_ff[`CTW_CC_N] == $past(dbl_ff[15]) && cc_ff[1:0] == 2'b00
         && cc_ff[`CTW_CC_Z] == ($past(dbl_ff[15:8]) == 8'h00) && $stable(dbl_ff));
    endproperty
    a_test_flags: assert property (p_test_flags) else $error("test flags wrong");
    property p_test_ext_len;
        (state_ff == ctw_pkg::ST_FETCH && run_ff && busRdata == `CTW_OP_TEST_EXT) |=> ##4
        (state_ff == ctw_pkg::ST_RUN && bus_ff.addr == `CTW_IDLE_ADDR)
        ##1 state_ff == ctw_pkg::ST_FETCH;
    endproperty
    a_test_ext_len: assert property (p_test_ext_len) else $error("test length wrong");
    property p_sp_to_x;
        (state_ff == ctw_pkg::ST_RUN && op_ff == `CTW_OP_STACK_TO_IDX && !preY_ff && !regWr)
        |-> bus_ff.addr == sp_ff
        ##1 (idxX_ff == $past(sp_ff) + 16'h0001 && $stable(sp_ff) && $stable(cc_ff));
    endproperty
    a_sp_to_x: assert property (p_sp_to_x) else $error("sp to x wrong");
    property p_y_to_sp;
        (state_ff == ctw_pkg::ST_RUN && op_ff == `CTW_OP_IDX_TO_STACK && preY_ff && !regWr)
        |-> bus_ff.addr == `CTW_IDLE_ADDR ##1 sp_ff == $past(idxY_ff) - 16'h0001;
    endproperty
    a_y_to_sp: assert property (p_y_to_sp) else $error("y to sp wrong");
    property p_push;
        (state_ff == ctw_pkg::ST_OP2 && op_ff == `CTW_OP_WAIT && !regWr) |=> s_pushes
        ##1 (state_ff == ctw_pkg::ST_WAIT && bus_ff.rw && bus_ff.addr == sp_ff + 16'h0001);
    endproperty
    a_push: assert property (p_push) else $error("stacking wrong");
    property p_wait_hold;
        (state_ff == ctw_pkg::ST_WAIT && !wakeNmx && !wakeIrq) |=>
        (state_ff == ctw_pkg::ST_WAIT && bus_ff.rw && $stable(bus_ff.addr));
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait idle wrong");
    property p_exit;
        (state_ff == ctw_pkg::ST_WAIT && (wakeNmx || wakeIrq)) |=>
        state_ff == ctw_pkg::ST_VEC_HI;
    endproperty
    a_exit: assert property (p_exit) else $error("wait not left");
    property p_vector;
        (state_ff == ctw_pkg::ST_WAIT && (wakeNmx || wakeIrq)) |=> s_vector;
    endproperty
    a_vector: assert property (p_vector) else $error("vector fetch wrong");
    property p_nmx_mask;
        (state_ff == ctw_pkg::ST_WAIT && wakeNmx) |=>
        (cc_ff[`CTW_CC_X] && bus_ff.addr == VEC_NMX);
    endproperty
    a_nmx_mask: assert property (p_nmx_mask) else $error("x mask not set");
    property p_masked;
        (state_ff == ctw_pkg::ST_WAIT && cc_ff[`CTW_CC_I] && cc_ff[`CTW_CC_X]) |=>
        state_ff == ctw_pkg::ST_WAIT;
    endproperty
    a_masked: assert property (p_masked) else $error("masked wake");
    property p_swap;
        (state_ff == ctw_pkg::ST_RUN && op_ff == `CTW_OP_SWAP_DBL && !preY_ff && !regWr)
        |-> bus_ff.addr == `CTW_IDLE_ADDR
        ##1 (idxX_ff == $past(dbl_ff) && dbl_ff == $past(idxX_ff) && $stable(cc_ff));
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");
endmodule : ctw_core

// *** bench/ctw_mem_model.sv ***
// Behavioural memory on the core's address/data bus
`timescale 1ns/1ns
module ctw_mem_model
(
    input  wire logic              core_clk, // Clock
    input  wire ctw_pkg::ctw_bus_t bus,      // Address, data, rw from core
    output logic [7:0]             busRdata  // Read data, same cycle
);
    logic [7:0] ram [0:65535];

    // Filler 01 decodes as a two-cycle no-op, so stray fetches stay harmless
    initial
    begin
        for (int i = 0; i < 65536; i++)
            ram[i] = 8'h01;
    end

    // Write cycles leave nothing useful on the read lines: show the inverse
    assign busRdata = bus.rw ? ram[bus.addr] : ~bus.wdata;

    always @(posedge core_clk)
    begin
        if (bus.rw === 1'b0)
            ram[bus.addr] <= bus.wdata;
    end
endmodule : ctw_mem_model

// *** bench/cpu_test_transfer_wait_ops_tb.sv ***
// Self-checking bench for the test, transfer, swap and wait core
`timescale 1ns/1ns
`include "ctw_cfg.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module cpu_test_transfer_wait_ops_tb;
    logic              core_clk      = 1'b0;
    logic              reset         = 1'b1;
    logic              irqReq        = 1'b0;
    logic              nonmaskExtReq = 1'b0;
    logic [2:0]        regAddr       = 3'h0;
    logic [15:0]       regWdata      = 16'h0000;
    logic              regWr         = 1'b0;
    logic              regRd         = 1'b0;
    logic              rdSeen        = 1'b0;
    logic [7:0]        busRdata;
    ctw_pkg::ctw_bus_t bus;
    logic [15:0]       regRdata;
    logic [15:0]       expQ[$];
    int                n_fail        = 0;
    int                tests_run     = 0;
    logic [15:0]       dbl, ix0, iy0, sp0;
    logic [7:0]        cc;
    logic [7:0]        opnd;
    logic [7:0]        stk [9];
    // Memory test runs last so the stacked flags depend on the random operand
    logic [7:0]        prog [14] = '{8'h8F, 8'h30, 8'h18, 8'h8F, 8'h18, 8'h35, 8'h35,
                                     8'h18, 8'h30, 8'h4D, 8'h7D, 8'h01, 8'h00, 8'h3E};

    always #5 core_clk = ~core_clk;

    ctw_core uut (.core_clk(core_clk), .reset(reset), .busRdata(busRdata), .irqReq(irqReq),
        .nonmaskExtReq(nonmaskExtReq), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .bus(bus), .regRdata(regRdata));
    ctw_mem_model mem (.core_clk(core_clk), .bus(bus), .busRdata(busRdata));

    always @(posedge core_clk)
    begin : watch
        logic [15:0] e;
        rdSeen <= regRd;
        if (rdSeen === 1'b1)
        begin
            e = expQ.pop_front();
            `CHK("regRdata", e, regRdata)
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge core_clk);
        regWr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        expQ.push_back(e);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd   <= 1'b0;
    endtask : rd

    task automatic seek(input logic [15:0] a, input logic rw, input int lim);
        int k;
        k = 0;
        while (!(bus.addr === a && bus.rw === rw) && k < lim)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        `CHK("busAddr", a, bus.addr)
    endtask : seek

    // Idle reads must keep hitting the stacked flag byte while no source may wake
    task automatic stay(input logic [15:0] a);
        repeat (20)
        begin
            @(posedge core_clk);
            #1;
            `CHK("idleAddr", a, bus.addr)
        end
    endtask : stay

    task automatic step(input logic [15:0] a);
        @(posedge core_clk);
        #1;
        `CHK("vecAddr", a, bus.addr)
    endtask : step

    initial
    begin
        dbl = 16'($urandom(32'h4C1C));
        ix0 = 16'($urandom);
        iy0 = 16'($urandom);
        opnd = 8'($urandom);
        sp0 = 16'hA800 ^ 16'($urandom & 32'h3FF);
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 14; i++)
            mem.ram[i] = prog[i];
        mem.ram[16'h0100] = opnd;
        mem.ram[16'hFFF0] = 8'h00;
        mem.ram[16'hFFF1] = 8'h40;
        mem.ram[16'hFFF2] = 8'h00;
        mem.ram[16'hFFF3] = 8'h50;
        mem.ram[16'h0040] = `CTW_OP_WAIT;
        mem.ram[16'h0050] = `CTW_OP_WAIT;
        rd(`CTW_REG_CC, 16'(`CTW_CC_RESET));
        rd(`CTW_REG_SP, 16'h0000);
        $display("test reset values done");
        wr(`CTW_REG_DBL, dbl);
        wr(`CTW_REG_IDX_X, ix0);
        wr(`CTW_REG_IDX_Y, iy0);
        wr(`CTW_REG_SP, sp0);
        wr(`CTW_REG_CC, 16'h0003);
        wr(`CTW_REG_RUN, 16'h0001);
        cc = {4'h0, opnd[7], opnd == 8'h00, 2'b00};
        stk = '{8'h0E, 8'h00, sp0[7:0] + 8'h01, 8'(sp0 + 16'h1 >> 8), sp0[7:0] + 8'h01,
                8'(sp0 + 16'h1 >> 8), iy0[15:8], iy0[7:0], cc};
        seek(sp0, 1'b0, 80);
        `CHK("pushData", 8'h0E, bus.wdata)
        seek(sp0 - 16'h8, 1'b1, 20);
        stay(sp0 - 16'h8);
        for (int i = 0; i < 9; i++)
            `CHK("stack", stk[i], mem.ram[sp0 - 16'(i)])
        `CHK("operand", opnd, mem.ram[16'h0100])
        $display("test transfers and first wait done");
        @(posedge core_clk);
        irqReq <= 1'b1;
        seek(16'hFFF0, 1'b1, 10);
        step(16'hFFF1);
        step(16'h0040);
        seek(sp0 - 16'h11, 1'b1, 40);
        stay(sp0 - 16'h11);
        `CHK("stackCc2", cc | 8'h10, mem.ram[sp0 - 16'h11])
        $display("test maskable wake done");
        @(posedge core_clk);
        nonmaskExtReq <= 1'b1;
        seek(16'hFFF2, 1'b1, 10);
        step(16'hFFF3);
        step(16'h0050);
        seek(sp0 - 16'h1A, 1'b1, 40);
        stay(sp0 - 16'h1A);
        $display("test external wake and masked wait done");
        rd(`CTW_REG_DBL, iy0);
        rd(`CTW_REG_IDX_X, sp0 + 16'h1);
        rd(`CTW_REG_IDX_Y, sp0 + 16'h1);
        rd(`CTW_REG_SP, sp0 - 16'h1B);
        rd(`CTW_REG_CC, {8'h00, cc | 8'h50});
        repeat (3) @(posedge core_clk);
        $display("test register readback done");
        conclude();
    end

    initial
    begin
        #50000;
        n_fail++;
        conclude();
    end
endmodule : cpu_test_transfer_wait_ops_tb
